// ===== rtl/vdmc_core.sv
// vdmc_core: per-frame decoder control word, frame scheduling and status word
// assumes the packet handler delivers decoded fields as one-cycle strobes
// Overview of operation
// [RULE1] encoder status flags stay out of outgoing packets by default.
// [RULE2] format field chooses flags in every packet or only when changed.
// [RULE3] each 20 ms frame hands the decoder a 16-bit control word.
// [RULE4] reset loads the control word from pins, other bits fixed zero.
// [RULE5] host may load the word via config field before decoding starts.
// [RULE6] a word supplied with a frame packet applies from that frame on.
// [RULE7] written control settings override the configuration pin levels.
// [RULE8] the control word holds its value until the host changes it.
// [RULE9] bit 2 requests frame repeat, discarding channel data; reset zero.
// [RULE10] bit 3 requests comfort noise from latest or default silence frame.
// [RULE11] bit 7 picks a-law when set, mu-law when clear, if companding.
// [RULE12] bit 8 enables companded samples, else 16-bit linear; pin reset.
// [RULE13] bit 14 requests tone synthesis, discarding channel data; reset zero.
// [RULE14] one channel frame goes to the decoder every 20 ms if available.
// [RULE15] each frame yields 160 plus or minus 4 speech samples.
// [RULE16] each frame yields a 16-bit decoder status word.
// [RULE17] missing channel frame forces repeat for that frame only.
// [RULE18] status bit 1 is 1 for voice or tone, 0 for comfort noise.
// [RULE19] status bit 5 set on repeat or error noise, clear on valid frame.
// [RULE20] status bit 15 set only for frames that decoded a tone.
// [RULE21] reserved control bits are written zero and ignored here.
`timescale 1ns/1ps
`default_nettype none
module vdmc_core #(
  parameter int FRAME_CYCLES = vdmc_pkg::FRAME_CYCLES,
  parameter int SAMPLES = vdmc_pkg::SAMPLES_NOM,
  parameter int DATA_W = 16,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // configuration pins
  input wire logic law_pin_i,
  input wire logic compand_pin_i,
  // configuration control packet fields
  input wire vdmc_pkg::vdmc_ctl_t decoder_control_config_field_i,
  input wire logic chfmt_valid_i,
  input wire logic [1:0] channel_format_config_field_i,
  input wire logic codec_run_i,
  // per-frame channel packet
  input wire vdmc_pkg::vdmc_ctl_t frame_ctl_i,
  input wire logic chan_valid_i,
  output logic chan_ready_o,
  input wire logic [DATA_W-1:0] chan_data_i,
  input wire logic chan_last_i,
  input wire logic chan_silence_i,
  input wire logic chan_error_i,
  // encoder status toward outgoing packets
  input wire logic enc_status_valid_i,
  input wire logic [15:0] encoder_status_flags_i,
  output logic enc_flags_insert_o,
  output logic [15:0] enc_flags_o,
  // decoder side
  output logic frame_start_o,
  output logic [15:0] decoder_frame_control_word_o,
  output logic dec_valid_o,
  input wire logic dec_ready_i,
  output logic [DATA_W-1:0] dec_data_o,
  output logic sample_valid_o,
  output logic [15:0] sample_count_o,
  output logic status_valid_o,
  output logic [15:0] decoder_frame_status_word_o,
  output logic silence_default_o
);
  initial begin
    if (SAMPLES < vdmc_pkg::SAMPLES_NOM - vdmc_pkg::SAMPLES_SKEW ||
        SAMPLES > vdmc_pkg::SAMPLES_NOM + vdmc_pkg::SAMPLES_SKEW || FRAME_CYCLES < SAMPLES + 4) begin
      $error("vdmc_core sample or frame count out of range");
    end
  end

  function automatic logic [15:0] ctl_clean(input logic [15:0] w);
    ctl_clean = w & vdmc_pkg::CTL_USED_MASK; // RULE21
  endfunction : ctl_clean

  function automatic vdmc_pkg::vdmc_dec_kind_t ctl_kind(input logic [15:0] w);
    if (w[vdmc_pkg::BIT_TONE]) ctl_kind = vdmc_pkg::VDMC_DEC_TONE;
    else if (w[vdmc_pkg::BIT_NOISE]) ctl_kind = vdmc_pkg::VDMC_DEC_NOISE;
    else if (w[vdmc_pkg::BIT_REPEAT]) ctl_kind = vdmc_pkg::VDMC_DEC_REPEAT;
    else ctl_kind = vdmc_pkg::VDMC_DEC_VOICE;
  endfunction : ctl_kind

  // ********************
  // stored control word
  // ********************
  logic [15:0] ctl_reg;
  logic [15:0] ctl_next;
  logic pins_taken_reg;
  logic run_reg;

  always_comb begin
    ctl_next = ctl_reg;
    if (!pins_taken_reg) begin
      ctl_next = vdmc_pkg::CTL_ZERO; // RULE4
      ctl_next[vdmc_pkg::BIT_LAW] = law_pin_i; // RULE11
      ctl_next[vdmc_pkg::BIT_COMPAND] = compand_pin_i; // RULE12
    end
    if (decoder_control_config_field_i.valid && !run_reg) begin
      ctl_next = ctl_clean(decoder_control_config_field_i.word); // RULE5 RULE7
    end
    if (frame_ctl_i.valid) begin
      ctl_next = ctl_clean(frame_ctl_i.word); // RULE6 RULE7
    end
  end

  // pins caught on the first clocked edge after release, not by reset itself
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctl_reg <= vdmc_pkg::CTL_ZERO;
      pins_taken_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next; // RULE8
      pins_taken_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      run_reg <= 1'b0;
    end else if (codec_run_i) begin
      run_reg <= 1'b1;
    end
  end

  // ********************
  // channel data buffer
  // ********************
  logic fifo_valid;
  logic fifo_ready;
  logic [DATA_W+1:0] fifo_data;
  logic [7:0] frames_reg;
  logic in_push;
  logic in_last_push;
  logic out_last_pop;
  logic discard_reg;

  vdmc_fifo #(.WIDTH(DATA_W + 2), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(chan_valid_i),
    .in_ready_o(chan_ready_o),
    .in_data_i({chan_error_i, chan_last_i, chan_data_i}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready),
    .out_data_o(fifo_data),
    .level_o()
  );

  assign in_push = chan_valid_i && chan_ready_o;
  assign in_last_push = in_push && chan_last_i;
  assign out_last_pop = fifo_valid && fifo_ready && fifo_data[DATA_W];

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      frames_reg <= 8'h00;
    end else begin
      frames_reg <= frames_reg + {7'h00, in_last_push} - {7'h00, out_last_pop};
    end
  end

  // ********************
  // frame scheduler
  // ********************
  logic [$clog2(FRAME_CYCLES)-1:0] tick_reg;
  logic frame_tick;
  logic [15:0] cur_ctl_reg;
  vdmc_pkg::vdmc_dec_kind_t kind_reg;
  logic sending_reg;
  logic [15:0] rep_mask;

  assign frame_tick = run_reg && (tick_reg == '0);
  assign rep_mask = (frames_reg == 8'h00) ? (16'h0001 << vdmc_pkg::BIT_REPEAT) : vdmc_pkg::CTL_ZERO;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !run_reg) begin
      tick_reg <= '0;
    end else if (tick_reg == ($clog2(FRAME_CYCLES))'(FRAME_CYCLES - 1)) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + 1'b1;
    end
  end

  // a missing frame forces repeat once without touching the stored word
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cur_ctl_reg <= vdmc_pkg::CTL_ZERO;
      kind_reg <= vdmc_pkg::VDMC_DEC_VOICE;
      sending_reg <= 1'b0;
      discard_reg <= 1'b0;
    end else if (frame_tick) begin
      cur_ctl_reg <= ctl_next | rep_mask; // RULE3 RULE17
      kind_reg <= ctl_kind(ctl_next | rep_mask);
      sending_reg <= (frames_reg != 8'h00); // RULE14
      discard_reg <= (ctl_kind(ctl_next) != vdmc_pkg::VDMC_DEC_VOICE); // RULE9 RULE10 RULE13
    end else if (out_last_pop) begin
      sending_reg <= 1'b0;
    end
  end

  assign frame_start_o = frame_tick;
  assign decoder_frame_control_word_o = cur_ctl_reg;
  assign dec_valid_o = sending_reg && fifo_valid && !discard_reg;
  assign fifo_ready = sending_reg && fifo_valid && (discard_reg || dec_ready_i);
  assign dec_data_o = fifo_data[DATA_W-1:0];

  // ********************
  // sample pacing and status word
  // ********************
  logic [15:0] samp_reg;
  logic [15:0] status_reg;
  logic status_v_reg;
  logic got_silence_reg;
  logic err_reg;
  logic [15:0] status_next;
  logic err_pop;

  // error mark rides with each word, so the frame tick cannot wipe it early
  assign err_pop = fifo_valid && fifo_ready && !discard_reg && fifo_data[DATA_W+1];

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || frame_tick) begin
      samp_reg <= 16'h0000;
    end else if (run_reg && samp_reg != 16'(SAMPLES)) begin
      samp_reg <= samp_reg + 16'h0001; // RULE15
    end
  end

  assign sample_valid_o = run_reg && !frame_tick && samp_reg != 16'(SAMPLES);
  assign sample_count_o = samp_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      got_silence_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      if (in_last_push && chan_silence_i) got_silence_reg <= 1'b1;
      if (frame_tick) err_reg <= 1'b0;
      else if (err_pop) err_reg <= 1'b1;
    end
  end

  assign silence_default_o = !got_silence_reg; // RULE10

  always_comb begin
    status_next = vdmc_pkg::CTL_ZERO;
    status_next[vdmc_pkg::STS_VOICE] = (kind_reg != vdmc_pkg::VDMC_DEC_NOISE) && !err_reg; // RULE18
    status_next[vdmc_pkg::STS_INVALID] = (kind_reg == vdmc_pkg::VDMC_DEC_REPEAT) || err_reg; // RULE19
    status_next[vdmc_pkg::STS_TONE] = (kind_reg == vdmc_pkg::VDMC_DEC_TONE); // RULE20
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      status_reg <= vdmc_pkg::CTL_ZERO;
      status_v_reg <= 1'b0;
    end else begin
      status_v_reg <= run_reg && (samp_reg == 16'(SAMPLES - 1)); // RULE16
      if (run_reg && samp_reg == 16'(SAMPLES - 1)) status_reg <= status_next;
    end
  end

  assign status_valid_o = status_v_reg;
  assign decoder_frame_status_word_o = status_reg;

  // ********************
  // encoder status flag insertion
  // ********************
  logic [1:0] chfmt_reg;
  logic [15:0] last_enc_reg;
  logic ins_reg;
  logic [15:0] enc_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      chfmt_reg <= vdmc_pkg::CHFMT_NONE; // RULE1
    end else if (chfmt_valid_i) begin
      chfmt_reg <= channel_format_config_field_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      last_enc_reg <= vdmc_pkg::CTL_ZERO;
      ins_reg <= 1'b0;
      enc_reg <= vdmc_pkg::CTL_ZERO;
    end else begin
      ins_reg <= 1'b0;
      if (enc_status_valid_i) begin
        last_enc_reg <= encoder_status_flags_i;
        enc_reg <= encoder_status_flags_i;
        ins_reg <= (chfmt_reg == vdmc_pkg::CHFMT_EVERY) ||
                   (chfmt_reg == vdmc_pkg::CHFMT_CHANGE &&
                    encoder_status_flags_i != last_enc_reg); // RULE2
      end
    end
  end

  assign enc_flags_insert_o = ins_reg;
  assign enc_flags_o = enc_reg;

  // ********************
  // checks
  // ********************
  property p_missing_repeat;
    @(posedge clock_i) disable iff (!rst_n_i)
    (frame_tick && frames_reg == 8'h00) |=> cur_ctl_reg[vdmc_pkg::BIT_REPEAT];
  endproperty
  a_missing_repeat: assert property (p_missing_repeat) else $error("no forced repeat"); // RULE17
  property p_store_kept;
    @(posedge clock_i) disable iff (!rst_n_i)
    (frame_tick && frames_reg == 8'h00 && !frame_ctl_i.valid) |=> $stable(ctl_reg);
  endproperty
  a_store_kept: assert property (p_store_kept) else $error("stored word changed"); // RULE17
  property p_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
    (pins_taken_reg && !frame_ctl_i.valid && !decoder_control_config_field_i.valid)
      |=> $stable(ctl_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("control word drifted"); // RULE8
  property p_reserved;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ctl_reg & ~vdmc_pkg::CTL_USED_MASK) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit kept"); // RULE21
  property p_default_off;
    @(posedge clock_i) disable iff (!rst_n_i)
    (chfmt_reg == vdmc_pkg::CHFMT_NONE) |=> !ins_reg;
  endproperty
  a_default_off: assert property (p_default_off) else $error("flags inserted"); // RULE1
  property p_tone_status;
    @(posedge clock_i) disable iff (!rst_n_i)
    status_v_reg |-> (status_reg[vdmc_pkg::STS_TONE] == (kind_reg == vdmc_pkg::VDMC_DEC_TONE));
  endproperty
  a_tone_status: assert property (p_tone_status) else $error("tone status wrong"); // RULE20
  property p_discard;
    @(posedge clock_i) disable iff (!rst_n_i)
    (cur_ctl_reg[vdmc_pkg::BIT_TONE] || cur_ctl_reg[vdmc_pkg::BIT_NOISE] ||
     cur_ctl_reg[vdmc_pkg::BIT_REPEAT]) |-> !dec_valid_o;
  endproperty
  a_discard: assert property (p_discard) else $error("data passed on discard"); // RULE9 RULE10 RULE13
  property p_status_once;
    @(posedge clock_i) disable iff (!rst_n_i)
    status_v_reg |=> !status_v_reg;
  endproperty
  a_status_once: assert property (p_status_once) else $error("status repeated"); // RULE16
  c_repeat: cover property (@(posedge clock_i) frame_tick && frames_reg == 8'h00 && run_reg);
  c_send: cover property (@(posedge clock_i) out_last_pop && dec_ready_i);
  c_change: cover property (@(posedge clock_i) ins_reg && chfmt_reg == vdmc_pkg::CHFMT_CHANGE);
endmodule : vdmc_core
`default_nettype wire

// ===== rtl/vdmc_fifo.sv
// vdmc_fifo: flip-flop fifo for channel data words
// assumes a single clock and synchronous active low reset
`timescale 1ns/1ps
`default_nettype none
module vdmc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("vdmc_fifo depth must be a power of two");
    end
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  logic push;
  logic pop;

  assign level_o = wr_reg - rd_reg;
  assign in_ready_o = (level_o != (AW + 1)'(DEPTH));
  assign out_valid_o = (wr_reg != rd_reg);
  assign out_data_o = mem_reg[rd_reg[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_reg <= '0;
    end else if (push) begin
      wr_reg <= wr_reg + 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_reg[wr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rd_reg <= '0;
    end else if (pop) begin
      rd_reg <= rd_reg + 1'b1;
    end
  end

  // full when pointers differ only in the wrap bit
  property p_no_overfill;
    @(posedge clock_i) disable iff (!rst_n_i)
    (level_o == (AW + 1)'(DEPTH)) |-> !in_ready_o;
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("fifo accepts while full");
endmodule : vdmc_fifo
`default_nettype wire

// ===== rtl/vdmc_pkg.sv
// vdmc_pkg: constants and carrier types for the decoder mode control block
// assumes one 200 MHz clock domain; used by vdmc_core and the bench, not by vdmc_fifo
package vdmc_pkg;

  // ********************
  // clock and frame timing
  // ********************
  localparam int CLK_MHZ = 200;
  localparam int FRAME_MS = 20;
  localparam int FRAME_CYCLES = FRAME_MS * 1000 * CLK_MHZ;
  localparam int SAMPLES_NOM = 160;
  localparam int SAMPLES_SKEW = 4;

  // ********************
  // control word layout
  // ********************
  localparam int CTL_W = 16;
  localparam int BIT_REPEAT = 2;
  localparam int BIT_NOISE = 3;
  localparam int BIT_LAW = 7;
  localparam int BIT_COMPAND = 8;
  localparam int BIT_TONE = 14;
  localparam logic [15:0] CTL_USED_MASK = 16'h418c;
  localparam logic [15:0] CTL_ZERO = 16'h0000;

  // ********************
  // status word layout
  // ********************
  localparam int STS_VOICE = 1;
  localparam int STS_INVALID = 5;
  localparam int STS_TONE = 15;

  // ********************
  // channel format field encoding
  // ********************
  localparam logic [1:0] CHFMT_NONE = 2'h0;
  localparam logic [1:0] CHFMT_EVERY = 2'h1;
  localparam logic [1:0] CHFMT_CHANGE = 2'h2;

  typedef enum logic [1:0] {
    VDMC_DEC_VOICE = 2'b00,
    VDMC_DEC_REPEAT = 2'b01,
    VDMC_DEC_NOISE = 2'b11,
    VDMC_DEC_TONE = 2'b10
  } vdmc_dec_kind_t;

  typedef struct packed {
    logic [15:0] word;
    logic valid;
  } vdmc_ctl_t;

  typedef struct packed {
    logic [15:0] samples;
    logic [15:0] status;
    vdmc_dec_kind_t kind;
  } vdmc_frame_t;

endpackage : vdmc_pkg

// ===== verification/test_vocoder_decoder_mode_control.sv
// test_vocoder_decoder_mode_control: self-checking bench for vdmc_core
// assumes a 400 cycle frame so the run stays short
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    tests_run++; \
    if ((got) !== (ex)) begin \
      $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
      err_count++; \
    end \
  end
module test_vocoder_decoder_mode_control;
  // ********************
  // clock, reset and wiring
  // ********************
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic law_pin_i;
  logic compand_pin_i;
  logic enc_status_valid_i;
  logic [15:0] encoder_status_flags_i;
  logic dec_ready_i;
  vdmc_pkg::vdmc_ctl_t cfg, fctl;
  logic chfmt_valid, codec_run, chan_valid, chan_ready, chan_last, chan_sil, chan_err;
  logic [1:0] chfmt;
  logic [15:0] chan_data, enc_flags, ctl_word, dec_data, smp_count, sts_word;
  logic enc_ins, frame_start, dec_valid, smp_valid, sts_valid, sil_default;
  int err_count = 0;
  int tests_run = 0;
  always #2.5 clock_i = ~clock_i;
  vdmc_host_model host (.clock_i(clock_i), .chan_ready_i(chan_ready), .cfg_o(cfg),
    .frame_ctl_o(fctl), .chfmt_valid_o(chfmt_valid), .chfmt_o(chfmt),
    .codec_run_o(codec_run), .chan_valid_o(chan_valid), .chan_data_o(chan_data),
    .chan_last_o(chan_last), .chan_silence_o(chan_sil), .chan_error_o(chan_err));
  // short frame keeps the run small; samples stay at the nominal count
  vdmc_core #(.FRAME_CYCLES(400)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .law_pin_i(law_pin_i),
    .compand_pin_i(compand_pin_i), .decoder_control_config_field_i(cfg),
    .chfmt_valid_i(chfmt_valid), .channel_format_config_field_i(chfmt),
    .codec_run_i(codec_run), .frame_ctl_i(fctl), .chan_valid_i(chan_valid),
    .chan_ready_o(chan_ready), .chan_data_i(chan_data), .chan_last_i(chan_last),
    .chan_silence_i(chan_sil), .chan_error_i(chan_err),
    .enc_status_valid_i(enc_status_valid_i), .encoder_status_flags_i(encoder_status_flags_i),
    .enc_flags_insert_o(enc_ins), .enc_flags_o(enc_flags), .frame_start_o(frame_start),
    .decoder_frame_control_word_o(ctl_word), .dec_valid_o(dec_valid),
    .dec_ready_i(dec_ready_i), .dec_data_o(dec_data), .sample_valid_o(smp_valid),
    .sample_count_o(smp_count), .status_valid_o(sts_valid),
    .decoder_frame_status_word_o(sts_word), .silence_default_o(sil_default));
  // ********************
  // shared tasks
  // ********************
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  task automatic final_report();
    err_count += host.hangs;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  task automatic do_reset(input logic law, input logic comp);
    host.set_run(1'b0);
    rst_n_i = 1'b0;
    law_pin_i = law;
    compand_pin_i = comp;
    enc_status_valid_i = 1'b0;
    encoder_status_flags_i = 16'h0000;
    dec_ready_i = 1'b1;
    tick(6);
    rst_n_i = 1'b1;
    tick(2);
  endtask : do_reset
  task automatic enc_pulse(input logic [15:0] f, output int ins);
    encoder_status_flags_i = f;
    enc_status_valid_i = 1'b1;
    tick(1);
    enc_status_valid_i = 1'b0;
    ins = 0;
    repeat (3) begin
      ins += (enc_ins === 1'b1);
      tick(1);
    end
  endtask : enc_pulse
  // decoder side stalls every other cycle while a frame drains
  task automatic run_frame(output logic [15:0] w, output logic [15:0] st,
                           output int ns, output int nd);
    int k;
    k = 0;
    while (frame_start !== 1'b1 && k < 500) begin
      tick(1);
      k++;
    end
    if (k == 500) begin
      err_count++;
      final_report();
    end
    tick(1);
    w = ctl_word;
    ns = 0;
    nd = 0;
    k = 0;
    while (sts_valid !== 1'b1 && k < 400) begin
      dec_ready_i = k[0];
      ns += (smp_valid === 1'b1);
      if (dec_valid === 1'b1 && dec_ready_i === 1'b1) begin
        `CHK("dec data", 16'h1000 + 16'(nd), dec_data)
      end
      nd += (dec_valid === 1'b1 && dec_ready_i === 1'b1);
      tick(1);
      k++;
    end
    if (k == 400) begin
      err_count++;
      final_report();
    end
    st = sts_word;
    `CHK("sample count", 16'(vdmc_pkg::SAMPLES_NOM), smp_count)
    dec_ready_i = 1'b1;
  endtask : run_frame
  // ********************
  // scenarios
  // ********************
  task automatic s_pins();
    logic [15:0] w, st;
    int ns, nd, ins;
    do_reset(1'b1, 1'b1);
    enc_pulse(16'h8002, ins);
    `CHK("flags by default", 0, ins)
    host.send_fmt(vdmc_pkg::CHFMT_EVERY);
    enc_pulse(16'h8002, ins);
    `CHK("flags every", 1, ins)
    `CHK("flags value", 16'h8002, enc_flags)
    host.send_fmt(vdmc_pkg::CHFMT_CHANGE);
    enc_pulse(16'h8002, ins);
    `CHK("flags unchanged", 0, ins)
    enc_pulse(16'h0002, ins);
    `CHK("flags changed", 1, ins)
    host.set_run(1'b1);
    run_frame(w, st, ns, nd);
    `CHK("pin word", 16'h0184, w)
    `CHK("samples", 160, ns)
    `CHK("repeat flag", 1'b1, st[5])
  endtask : s_pins
  task automatic s_config();
    logic [15:0] w, st;
    int ns, nd;
    do_reset(1'b0, 1'b1);
    `CHK("no silence yet", 1'b1, sil_default)
    host.send_cfg(16'h0283);
    host.send_frame(16, 1'b0, 1'b0, 1'b0, 16'h0000);
    tick(1);
    `CHK("fifo full", 1'b0, chan_ready)
    host.set_run(1'b1);
    run_frame(w, st, ns, nd);
    `CHK("config word", 16'h0080, w)
    `CHK("words to decoder", 16, nd)
    `CHK("voice status", 16'h0002, st)
    `CHK("fifo drained", 1'b0, dec_valid)
    // a late config field must be ignored once frames run
    host.send_cfg(16'h0100);
    run_frame(w, st, ns, nd);
    `CHK("missing frame word", 16'h0084, w)
    host.send_frame(4, 1'b1, 1'b0, 1'b0, 16'h0000);
    run_frame(w, st, ns, nd);
    `CHK("restored word", 16'h0080, w)
    `CHK("silence seen", 1'b0, sil_default)
  endtask : s_config
  task automatic s_ctl();
    logic [15:0] w, st;
    int ns, nd;
    host.send_frame(4, 1'b0, 1'b0, 1'b1, 16'h4000);
    run_frame(w, st, ns, nd);
    `CHK("tone word", 16'h4000, w)
    `CHK("tone discard", 0, nd)
    `CHK("tone status", 2'b11, {st[15], st[1]})
    host.send_frame(4, 1'b0, 1'b0, 1'b1, 16'h0008);
    run_frame(w, st, ns, nd);
    `CHK("noise word", 16'h0008, w)
    `CHK("noise status", 2'b00, {st[15], st[1]})
    host.send_frame(4, 1'b0, 1'b0, 1'b1, 16'h0004);
    run_frame(w, st, ns, nd);
    `CHK("repeat word", 16'h0004, w)
    `CHK("repeat status", 1'b1, st[5])
    host.send_frame(4, 1'b0, 1'b1, 1'b1, 16'h0000);
    run_frame(w, st, ns, nd);
    `CHK("cleared word", 16'h0000, w)
    `CHK("error status", 2'b10, {st[5], st[1]})
  endtask : s_ctl
  initial begin
    s_pins();
    s_config();
    s_ctl();
    final_report();
  end
endmodule : test_vocoder_decoder_mode_control
`default_nettype wire

// ===== verification/vdmc_host_model.sv
// vdmc_host_model: host that sends config fields and channel frames
// assumes its tasks are called 1 ns after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module vdmc_host_model (
  // clock
  input wire logic clock_i,
  // flow control from the device
  input wire logic chan_ready_i,
  // packets toward the device
  output var vdmc_pkg::vdmc_ctl_t cfg_o,
  output var vdmc_pkg::vdmc_ctl_t frame_ctl_o,
  output logic chfmt_valid_o,
  output logic [1:0] chfmt_o,
  output logic codec_run_o,
  output logic chan_valid_o,
  output logic [15:0] chan_data_o,
  output logic chan_last_o,
  output logic chan_silence_o,
  output logic chan_error_o
);
  // ********************
  // host tasks
  // ********************
  int hangs = 0;
  initial begin
    cfg_o = '0;
    frame_ctl_o = '0;
    chfmt_valid_o = 1'b0;
    chfmt_o = 2'h0;
    codec_run_o = 1'b0;
    chan_valid_o = 1'b0;
    chan_data_o = 16'h0000;
    chan_last_o = 1'b0;
    chan_silence_o = 1'b0;
    chan_error_o = 1'b0;
  end
  task automatic set_run(input logic r);
    codec_run_o = r;
  endtask : set_run
  // released fields show inverted data so a stale value never passes
  task automatic send_cfg(input logic [15:0] w);
    cfg_o = '{word: w, valid: 1'b1};
    @(posedge clock_i);
    #1 cfg_o = '{word: ~w, valid: 1'b0};
  endtask : send_cfg
  task automatic send_fmt(input logic [1:0] f);
    chfmt_o = f;
    chfmt_valid_o = 1'b1;
    @(posedge clock_i);
    #1 chfmt_valid_o = 1'b0;
    chfmt_o = ~f;
  endtask : send_fmt
  task automatic send_frame(input int n, input logic sil, input logic err,
                            input logic use_ctl, input logic [15:0] ctl);
    int k;
    if (use_ctl) begin
      frame_ctl_o = '{word: ctl, valid: 1'b1};
      @(posedge clock_i);
      #1 frame_ctl_o = '{word: ~ctl, valid: 1'b0};
    end
    for (int i = 0; i < n; i++) begin
      chan_valid_o = 1'b1;
      chan_data_o = 16'h1000 + 16'(i);
      chan_last_o = (i == n - 1);
      chan_silence_o = sil && (i == n - 1);
      chan_error_o = err;
      k = 0;
      // ready only moves on edges, so it is judged settled before the taking edge
      while (chan_ready_i !== 1'b1 && k < 600) begin
        k++;
        @(posedge clock_i);
        #1;
      end
      hangs += (k == 600);
      @(posedge clock_i);
      #1;
    end
    chan_valid_o = 1'b0;
    chan_data_o = ~chan_data_o;
    chan_last_o = ~chan_last_o;
  endtask : send_frame
endmodule : vdmc_host_model
`default_nettype wire
